// ---- rtl/ths_track_hold_sequencer.sv ----
// Track/hold sequencer: picks the control source, forwards it, and drives
// the track/hold state with a scan-entry hold counter.
// Assumes a classic Wishbone master on clk and asynchronous pin inputs.
// Select changes in mid-scan are not filtered: a source swap can
// look like a rising edge, so software reprograms while idle.
//
// The implementer's own choices: the register offsets and register access over Wishbone.
module ths_track_hold_sequencer
	import ths_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        host_counter_two_output_i,
	output logic             host_counter_two_output_o,
	output logic             host_counter_two_output_oe_n,
	input  wire logic        external_hold_trigger_pin_i,
	output logic             external_hold_trigger_pin_o,
	output logic             external_hold_trigger_pin_oe_n,
	input  wire logic        backplane_trigger_bus_i,
	output logic             backplane_trigger_bus_o,
	output logic             backplane_trigger_bus_oe_n,
	input  wire logic        scan_enable_i,
	input  wire logic        scan_interval_end_i,
	output logic             hold_o
);
	import ths_pkg::*;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// Field compare, shared by the three select decoders
	function automatic logic code_is(
		input logic [1:0] field,
		input logic [1:0] code
	);
		return field == code;
	endfunction

	// Address match, shared by the read mux and the write strobes
	function automatic logic adr_hit(
		input logic [7:0] adr,
		input logic [7:0] ofs
	);
		return adr == ofs;
	endfunction

	// One-cycle rise of a synchronised level against its last value
	function automatic logic rose(
		input logic now,
		input logic last
	);
		return now && !last;
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [6:0]       ctrl_q;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] entries_q;
	ths_state_type    state_q;
	ths_state_type    state_d;
	logic [CNT_W-1:0] entries_d;
	logic             ctl_prev_q;
	logic             en_prev_q;
	logic             end_prev_q;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [4:0] sync_w;

	ths_sync #(.WIDTH(5)) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in ({scan_interval_end_i, scan_enable_i,
		            backplane_trigger_bus_i, external_hold_trigger_pin_i,
		            host_counter_two_output_i}),
		.sync_out (sync_w)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire [1:0] opsel_w  = ctrl_q[THS_OPSEL_LSB +: 2];
	wire [1:0] srcsel_w = ctrl_q[THS_SRCSEL_LSB +: 2];
	wire [1:0] fwdsel_w = ctrl_q[THS_FWDSEL_LSB +: 2];
	wire       simple_w = ctrl_q[THS_SIMPLE_BIT];

	// ----------------------------------------------------------------
	// Operation decode
	// ----------------------------------------------------------------
	wire op_single_w   = code_is(opsel_w, THS_OP_SINGLE);
	wire op_interval_w = code_is(opsel_w, THS_OP_INTERVAL);
	wire active_w      = op_single_w || op_interval_w;

	// ----------------------------------------------------------------
	// Source decode
	// ----------------------------------------------------------------
	// Pin source refused with the simple host variant
	wire src_pin_w = code_is(srcsel_w, THS_SRC_PIN) && !simple_w;
	wire src_bus_w = code_is(srcsel_w, THS_SRC_BUS);
	wire src_ctr_w = !src_pin_w && !src_bus_w;

	// Each source reads its own line: bus from sync bit 2, pin from bit 1, counter from bit 0
	wire ctl_w = src_bus_w ? sync_w[2] :
	             src_pin_w ? sync_w[1] : sync_w[0];

	// ----------------------------------------------------------------
	// Forward decode
	// ----------------------------------------------------------------
	wire fwd_h_sel_w = code_is(fwdsel_w, THS_FWD_HOST);
	wire fwd_b_sel_w = code_is(fwdsel_w, THS_FWD_BUS);
	wire fwd_host_w  = active_w &&
		(src_pin_w || (fwd_h_sel_w && !src_ctr_w));
	wire fwd_pin_w   = active_w && fwd_h_sel_w && !src_pin_w;
	// Single bus driver is software's duty; no arbitration here
	wire fwd_bus_w   = active_w && fwd_b_sel_w && !src_bus_w;

	// ----------------------------------------------------------------
	// Edge detect and hold entry count
	// ----------------------------------------------------------------
	wire rise_w     = rose(ctl_w, ctl_prev_q);
	wire en_rise_w  = rose(sync_w[3], en_prev_q);
	wire end_rise_w = rose(sync_w[4], end_prev_q);
	wire [CNT_W-1:0] next_ent_w = entries_q + {{(CNT_W-1){1'b0}}, 1'b1};
	// Count register holds n-1 so eight bits reach 256
	wire count_done_w = en_rise_w && (entries_q == count_q);

	// ----------------------------------------------------------------
	// Track/hold sequencing
	// ----------------------------------------------------------------
	always_comb begin
		state_d   = state_q;
		entries_d = entries_q;
		case (opsel_w)
			THS_OP_SINGLE: begin
				state_d   = ctl_w ? THS_HOLD : THS_TRACK;
				entries_d = '0;
			end
			THS_OP_INTERVAL: begin
				case (state_q)
					THS_TRACK: begin
						if (rise_w) begin
							state_d   = THS_HOLD;
							entries_d = '0;
						end
					end
					THS_HOLD: begin
						if (simple_w) begin
							if (end_rise_w)
								state_d = THS_TRACK;
						end else if (count_done_w) begin
							state_d   = THS_TRACK;
							entries_d = '0;
						end else if (en_rise_w) begin
							entries_d = next_ent_w;
						end
					end
					default: state_d = THS_TRACK;
				endcase
			end
			default: begin
				state_d   = THS_TRACK;
				entries_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q   <= THS_TRACK;
			entries_q <= '0;
		end else begin
			state_q   <= state_d;
			entries_q <= entries_d;
		end
	end

	// ----------------------------------------------------------------
	// Edge history
	// ----------------------------------------------------------------
	// Cleared to the idle level of every line, so no false edge at reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctl_prev_q <= 1'b0;
			en_prev_q  <= 1'b0;
			end_prev_q <= 1'b0;
		end else begin
			ctl_prev_q <= ctl_w;
			en_prev_q  <= sync_w[3];
			end_prev_q <= sync_w[4];
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	localparam int N_PIN = 3;
	// Index 0 host counter line, 1 external pin, 2 backplane line
	logic [N_PIN-1:0] pin_en_w;
	logic             pin_o_q    [N_PIN];
	logic             pin_oe_n_q [N_PIN];

	assign pin_en_w = {fwd_bus_w, fwd_pin_w, fwd_host_w};

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			hold_o <= 1'b0;
		else
			hold_o <= (state_d == THS_HOLD);
	end

	// Every line carries the control level; oe_n alone picks drivers
	for (genvar gi = 0; gi < N_PIN; gi++) begin : g_pin
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				pin_o_q[gi]    <= 1'b0;
				pin_oe_n_q[gi] <= 1'b1;
			end else begin
				pin_o_q[gi]    <= ctl_w;
				pin_oe_n_q[gi] <= !pin_en_w[gi];
			end
		end
	end

	assign host_counter_two_output_o      = pin_o_q[0];
	assign host_counter_two_output_oe_n   = pin_oe_n_q[0];
	assign external_hold_trigger_pin_o    = pin_o_q[1];
	assign external_hold_trigger_pin_oe_n = pin_oe_n_q[1];
	assign backplane_trigger_bus_o        = pin_o_q[2];
	assign backplane_trigger_bus_oe_n     = pin_oe_n_q[2];

	// ----------------------------------------------------------------
	// Wishbone slave, one wait state, ack drops after one cycle
	// ----------------------------------------------------------------
	wire req_w   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_w    = req_w && wb_we_i && wb_sel_i[0];
	wire hit_c_w = adr_hit(wb_adr_i, THS_CTRL_OFS);
	wire hit_n_w = adr_hit(wb_adr_i, THS_COUNT_OFS);
	wire hit_s_w = adr_hit(wb_adr_i, THS_STATUS_OFS);

	logic [31:0] status_w;

	// Fields placed by position so the layout lives in one place
	always_comb begin
		status_w                          = 32'h0000_0000;
		status_w[THS_ST_HOLD_BIT]         = hold_o;
		status_w[THS_ST_CTR_BIT]          = active_w &&
		                                    (src_pin_w || src_ctr_w);
		status_w[THS_ST_BUS_BIT]          = !backplane_trigger_bus_oe_n;
		status_w[THS_ST_CNT_LSB +: CNT_W] = entries_q;
	end

	wire [31:0] rdata_w = hit_c_w ? {25'h0, ctrl_q} :
	                      hit_n_w ? {{(32-CNT_W){1'b0}}, count_q} :
	                      hit_s_w ? status_w : 32'h0000_0000;

	// Answer path: ack and read data stand one cycle each
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req_w;
			wb_dat_o <= req_w ? rdata_w : 32'h0000_0000;
		end
	end

	// Register writes land on the taking edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_q  <= THS_CTRL_RST;
			count_q <= CNT_W'(THS_COUNT_RST);
		end else begin
			if (wr_w && hit_c_w)
				ctrl_q <= wb_dat_i[6:0];
			if (wr_w && hit_n_w)
				count_q <= wb_dat_i[CNT_W-1:0];
		end
	end
endmodule

// ---- rtl/ths_pkg.sv ----
// Shared constants for the track/hold sequencer block.
// Assumes a 32-bit classic Wishbone slave port and a 50 MHz clock.
package ths_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] THS_CTRL_OFS   = 8'h00;
	localparam logic [7:0] THS_COUNT_OFS  = 8'h04;
	localparam logic [7:0] THS_STATUS_OFS = 8'h08;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int THS_OPSEL_LSB  = 0;
	localparam int THS_SRCSEL_LSB = 2;
	localparam int THS_FWDSEL_LSB = 4;
	localparam int THS_SIMPLE_BIT = 6;

	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int THS_ST_HOLD_BIT  = 0;
	localparam int THS_ST_CTR_BIT   = 1;
	localparam int THS_ST_BUS_BIT   = 2;
	localparam int THS_ST_CNT_LSB   = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] THS_CTRL_RST  = 7'h00;
	localparam logic [7:0] THS_COUNT_RST = 8'h00;

	// Select codes
	localparam logic [1:0] THS_OP_OFF      = 2'h0;
	localparam logic [1:0] THS_OP_SINGLE   = 2'h1;
	localparam logic [1:0] THS_OP_INTERVAL = 2'h2;
	localparam logic [1:0] THS_SRC_COUNTER = 2'h0;
	localparam logic [1:0] THS_SRC_PIN     = 2'h1;
	localparam logic [1:0] THS_SRC_BUS     = 2'h2;
	localparam logic [1:0] THS_FWD_NONE    = 2'h0;
	localparam logic [1:0] THS_FWD_HOST    = 2'h1;
	localparam logic [1:0] THS_FWD_BUS     = 2'h2;

	typedef enum logic [0:0] {
		THS_TRACK,
		THS_HOLD
	} ths_state_type;

endpackage

// ---- rtl/ths_sync.sv ----
// Two-flop synchroniser for levels entering the clk domain.
// Assumes the input is asynchronous to clk.
module ths_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ---- testbench/ths_asserts.sv ----
// Checker for the sequencer's bus handshake, readback and idle state.
// Assumes binding onto the top module; sees its ports only.
module ths_asserts
	import ths_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        backplane_trigger_bus_oe_n,
	input wire logic        hold_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire rd = wb_cyc_i && wb_stb_i && !wb_we_i;
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	chk_ack_cause: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_reset_idle: assert property ($fell(reset) |-> !hold_o
		&& backplane_trigger_bus_oe_n && !wb_ack_o)
		else $error("outputs busy after reset");
	chk_unmapped_zero: assert property (wb_ack_o &&
		$past(rd && wb_adr_i > THS_STATUS_OFS) |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_ctrl_width: assert property (wb_ack_o &&
		$past(rd && wb_adr_i == THS_CTRL_OFS) |-> wb_dat_o[31:7] == 25'h0)
		else $error("control upper bits set");
	chk_count_width: assert property (wb_ack_o &&
		$past(rd && wb_adr_i == THS_COUNT_OFS) |-> wb_dat_o[31:8] == 24'h0)
		else $error("count upper bits set");
	chk_status_hold: assert property (wb_ack_o &&
		$past(rd && wb_adr_i == THS_STATUS_OFS) |-> wb_dat_o[0] == $past(hold_o))
		else $error("status hold bit differs");
	cov_hold: cover property ($rose(hold_o));
	cov_bus_drive: cover property (!backplane_trigger_bus_oe_n);
	cov_read: cover property (wb_ack_o && !wb_we_i);
endmodule
bind ths_track_hold_sequencer ths_asserts ths_asserts_inst (.*);

// ---- testbench/ths_host.sv ----
// Host board model: counter two output and scan strobes.
// Assumes the device drives the shared counter line while oe_n is low.
module ths_host (
	input  wire logic clk,
	input  wire logic dev_o,
	input  wire logic dev_oe_n,
	output wire logic line,
	output wire logic sen,
	output wire logic send
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] v_q = 3'h0;
	assign line = dev_oe_n ? v_q[2] : dev_o;
	assign sen = v_q[1];
	assign send = v_q[0];
	task automatic level(input logic [2:0] m);
		@(posedge clk);
		v_q <= m;
	endtask
	// Strobe stays up for four clocks, then drops before the task returns
	task automatic pulse(input logic [2:0] m);
		level(m);
		repeat (3) @(posedge clk);
		level(3'h0);
		repeat (3) @(posedge clk);
	endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the track/hold sequencer.
// Assumes the host model owns the counter line and the scan strobes.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ths_pkg::*;
	logic        clk, reset, cyc, stb, we, ack, hc_o, hc_oe_n, hc;
	logic        pin, pin_o, pin_oe_n, bp, bp_o, bp_oe_n, sen, send, hold;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, r;
	int          miscompares = 0;
	int          n_checks = 0;
	wire         pin_w = pin_oe_n ? pin : pin_o;
	wire         bp_w = bp_oe_n ? bp : bp_o;
	ths_track_hold_sequencer ths_track_hold_sequencer_inst (
		.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .host_counter_two_output_i(hc),
		.host_counter_two_output_o(hc_o),
		.host_counter_two_output_oe_n(hc_oe_n),
		.external_hold_trigger_pin_i(pin_w),
		.external_hold_trigger_pin_o(pin_o),
		.external_hold_trigger_pin_oe_n(pin_oe_n),
		.backplane_trigger_bus_i(bp_w), .backplane_trigger_bus_o(bp_o),
		.backplane_trigger_bus_oe_n(bp_oe_n), .scan_enable_i(sen),
		.scan_interval_end_i(send), .hold_o(hold));
	ths_host ths_host_inst (.clk(clk), .dev_o(hc_o), .dev_oe_n(hc_oe_n),
		.line(hc), .sen(sen), .send(send));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input int d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= 32'(d);
		do @(posedge clk); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic t_regs();
		wb(1'b0, THS_CTRL_OFS, 0);
		chk(r, 32'h0);
		wb(1'b0, THS_COUNT_OFS, 0);
		chk(r, 32'h0);
		wb(1'b1, THS_COUNT_OFS, 2);
		sel <= 4'he;
		wb(1'b1, THS_COUNT_OFS, 5);
		sel <= 4'hf;
		wb(1'b0, THS_COUNT_OFS, 0);
		chk(r, 32'h2);
		wb(1'b0, 8'h0c, 0);
		chk(r, 32'h0);
	endtask
	task automatic t_pin();
		wb(1'b1, THS_CTRL_OFS, 'h05);
		pin <= 1'b1;
		wt(4);
		chk(32'({hold, hc}), 32'h3);
		pin <= 1'b0;
		wt(4);
		chk(32'(hold), 32'h0);
	endtask
	task automatic t_bus();
		wb(1'b1, THS_CTRL_OFS, 'h21);
		ths_host_inst.level(3'h4);
		wt(4);
		chk(32'({hold, bp_w, bp_oe_n}), 32'h6);
		wb(1'b1, THS_CTRL_OFS, 'h11);
		wt(4);
		chk(32'({pin_w, pin_oe_n, hc_oe_n}), 32'h5);
		ths_host_inst.level(3'h0);
		wb(1'b1, THS_CTRL_OFS, 'h09);
		bp <= 1'b1;
		wt(4);
		chk(32'({hold, bp_oe_n}), 32'h3);
		bp <= 1'b0;
		wt(4);
		chk(32'(hold), 32'h0);
	endtask
	task automatic t_interval(input int c, input int n, input logic e);
		wb(1'b1, THS_CTRL_OFS, c);
		ths_host_inst.pulse(3'h4);
		wb(1'b0, THS_STATUS_OFS, 0);
		chk(32'(r[0]), 32'h1);
		repeat (n) ths_host_inst.pulse(3'h2);
		chk(32'(hold), 32'(e));
		ths_host_inst.pulse(c[6] ? 3'h1 : 3'h2);
		chk(32'(hold), 32'h0);
	endtask
	task automatic t_off();
		wb(1'b1, THS_CTRL_OFS, 'h14);
		pin <= 1'b1;
		wt(4);
		chk(32'({hold, hc_oe_n, pin_oe_n, bp_oe_n}), 32'h7);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		{cyc, stb, we, pin, bp, adr, wdat} = '0;
		sel = 4'hf;
		wt(8);
		reset <= 1'b0;
		t_regs();
		t_pin();
		t_bus();
		t_interval('h02, 2, 1'b1);
		t_interval('h42, 3, 1'b1);
		t_off();
		stop_test();
	end
	initial begin
		wt(5000);
		miscompares++;
		stop_test();
	end
endmodule
